// ---- logic/scrst_regs.vh ----
// Register map, field positions and timing constants for the sensor control block
`ifndef SCRST_REGS_VH
`define SCRST_REGS_VH
`define SCRST_ADDR_CTRL1     8'h15
`define SCRST_BIT_RESET      7
`define SCRST_BIT_AXIS_HI    6
`define SCRST_BIT_AXIS_LO    5
`define SCRST_BIT_DIR        4
`define SCRST_BIT_WIRE3      3
`define SCRST_BIT_FSR_HI     2
`define SCRST_BIT_FSR_LO     1
`define SCRST_BIT_ACTIVE     0
`define SCRST_AXIS_OFF       2'h0
`define SCRST_AXIS_X         2'h1
`define SCRST_AXIS_Z         2'h2
`define SCRST_CTRL1_RESET    8'h00
`define SCRST_CLK_HZ         10000000
`define SCRST_DELAY_MIN_US   300
`define SCRST_DELAY_MAX_US   500
`define SCRST_DELAY_US       400
`define SCRST_PULSE_CYCLES   4
`endif

// ---- logic/scrst_delay.v ----
// Countdown timer that launches the deferred soft reset sequence
`timescale 1ns/10ps
module scrst_delay #(
  parameter WIDTH = 16
) (
  input  wire             i_clk,
  input  wire             i_srst,
  input  wire             i_start,
  input  wire [WIDTH-1:0] i_count,
  output reg              o_busy,
  output reg              o_done
);
  reg [WIDTH-1:0] remain;

  always @(posedge i_clk) begin
    if (i_srst) begin
      remain <= {WIDTH{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        remain <= i_count;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (remain == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ---- logic/scrst_ctrl.v ----
// Sensor control register one: soft reset, self-test, SPI wire mode, range and active bits
`timescale 1ns/10ps
`include "scrst_regs.vh"
module scrst_ctrl #(
  parameter CLK_HZ     = `SCRST_CLK_HZ,
  parameter DELAY_US   = `SCRST_DELAY_US,
  parameter CNT_WIDTH  = 16,
  parameter PULSE_CYC  = `SCRST_PULSE_CYCLES
) (
  input  wire       i_clk,
  input  wire       i_srst,
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_txn_end,
  input  wire       i_host_interface_choice_pin,
  input  wire       i_lines_tied,
  input  wire       i_hibernate_exit,
  input  wire       i_irq_pin_polarity,
  input  wire       i_irq_pin_drive_type,
  input  wire       i_boot_pulse_disable,
  output reg  [7:0] o_rd_data,
  output reg        o_soft_reset,
  output reg        o_bus_reset,
  output reg        o_reset_pending,
  output reg        o_selftest_on,
  output reg        o_selftest_x,
  output reg        o_selftest_z,
  output reg        o_selftest_direction,
  output reg        o_three_wire,
  output reg        o_data_out_oe_allow,
  output reg  [1:0] o_fsr,
  output reg        o_active,
  output reg        o_keep_irq_pin_polarity,
  output reg        o_keep_irq_pin_drive_type,
  output reg        o_keep_boot_pulse_disable
);
  // DELAY_US rounds up to whole cycles; the chosen midpoint sits well inside the window
  localparam [31:0]          DELAY_CALC = (DELAY_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam [31:0]          PULSE_CALC = PULSE_CYC;
  localparam [CNT_WIDTH-1:0] DELAY_CYC  = DELAY_CALC[CNT_WIDTH-1:0];
  localparam [7:0]           PULSE_W    = PULSE_CALC[7:0];

  // Interface select and tied-line sense come from pins
  reg       sel_meta;
  reg       sel_sync;
  reg       tie_meta;
  reg       tie_sync;
  reg       txn_meta;
  reg       txn_sync;
  reg       hib_meta;
  reg       hib_sync;
  reg       hib_prev;

  reg [1:0] selftest_axis_choice;
  reg       selftest_direction;
  reg       wire_bit;
  reg [1:0] fsr;
  reg       active;

  reg       armed;
  reg       bus_open;
  reg       timer_start;
  reg [7:0] pulse_cnt;

  wire      hit;
  wire      rst_wr;
  wire      timer_busy;
  wire      timer_done;
  wire      int_reset;
  wire      spi_sel;
  wire      next_three_wire;

  assign hit    = (i_addr == `SCRST_ADDR_CTRL1);
  assign rst_wr = i_wr_en && hit && i_wr_data[`SCRST_BIT_RESET];
  assign int_reset = (pulse_cnt != 8'h00);
  assign spi_sel = sel_sync;
  assign next_three_wire = spi_sel && (wire_bit || tie_sync);

  always @(posedge i_clk) begin
    if (i_srst) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      tie_meta <= 1'b0;
      tie_sync <= 1'b0;
      txn_meta <= 1'b1;
      txn_sync <= 1'b1;
      hib_meta <= 1'b0;
      hib_sync <= 1'b0;
      hib_prev <= 1'b0;
    end else begin
      sel_meta <= i_host_interface_choice_pin;
      sel_sync <= sel_meta;
      tie_meta <= i_lines_tied;
      tie_sync <= tie_meta;
      txn_meta <= i_txn_end;
      txn_sync <= txn_meta;
      hib_meta <= i_hibernate_exit;
      hib_sync <= hib_meta;
      hib_prev <= hib_sync;
    end
  end

  // Write to a mode field is ignored while a soft reset is armed or its pulse is running
  always @(posedge i_clk) begin
    if (i_srst || int_reset) begin
      selftest_axis_choice <= `SCRST_AXIS_OFF;
      selftest_direction   <= 1'b0;
      wire_bit             <= 1'b0;
      fsr                  <= 2'h0;
      active               <= 1'b0;
    end else begin
      if (i_wr_en && hit && !armed) begin
        selftest_axis_choice <= i_wr_data[`SCRST_BIT_AXIS_HI:`SCRST_BIT_AXIS_LO];
        selftest_direction   <= i_wr_data[`SCRST_BIT_DIR];
        wire_bit             <= i_wr_data[`SCRST_BIT_WIRE3];
        fsr                  <= i_wr_data[`SCRST_BIT_FSR_HI:`SCRST_BIT_FSR_LO];
        active               <= i_wr_data[`SCRST_BIT_ACTIVE];
      end
      if (hib_sync && !hib_prev) begin
        wire_bit <= 1'b0;
      end
    end
  end

  // Arm on the write, hold until the transaction closes, then time the delay
  always @(posedge i_clk) begin
    if (i_srst || int_reset) begin
      armed       <= 1'b0;
      bus_open    <= 1'b0;
      timer_start <= 1'b0;
    end else begin
      timer_start <= 1'b0;
      if (rst_wr) begin
        armed <= 1'b1;
      end
      // Synced end flag lags the write, so only a close seen after arming counts
      if (armed && !txn_sync) begin
        bus_open <= 1'b1;
      end
      if (armed && bus_open && txn_sync && !timer_busy && !timer_start) begin
        timer_start <= 1'b1;
        bus_open    <= 1'b0;
      end
    end
  end

  scrst_delay #(
    .WIDTH (CNT_WIDTH)
  ) u_delay (
    .i_clk   (i_clk),
    .i_srst  (i_srst || int_reset),
    .i_start (timer_start),
    .i_count (DELAY_CYC),
    .o_busy  (timer_busy),
    .o_done  (timer_done)
  );

  always @(posedge i_clk) begin
    if (i_srst) begin
      pulse_cnt <= 8'h00;
    end else if (timer_done) begin
      pulse_cnt <= PULSE_W;
    end else if (int_reset) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rd_data                 <= 8'h00;
      o_soft_reset              <= 1'b0;
      o_bus_reset               <= 1'b0;
      o_reset_pending           <= 1'b0;
      o_selftest_on             <= 1'b0;
      o_selftest_x              <= 1'b0;
      o_selftest_z              <= 1'b0;
      o_selftest_direction      <= 1'b0;
      o_three_wire              <= 1'b0;
      o_data_out_oe_allow       <= 1'b1;
      o_fsr                     <= 2'h0;
      o_active                  <= 1'b0;
      o_keep_irq_pin_polarity   <= 1'b0;
      o_keep_irq_pin_drive_type <= 1'b0;
      o_keep_boot_pulse_disable <= 1'b0;
    end else begin
      o_soft_reset    <= int_reset;
      o_bus_reset     <= int_reset;
      o_reset_pending <= armed;
      if (i_rd_en && hit) begin
        o_rd_data <= {1'b0, selftest_axis_choice, selftest_direction,
                      wire_bit, fsr, active};
      end else begin
        o_rd_data <= 8'h00;
      end
      o_selftest_on        <= (selftest_axis_choice != `SCRST_AXIS_OFF);
      o_selftest_x         <= (selftest_axis_choice == `SCRST_AXIS_X);
      o_selftest_z         <= (selftest_axis_choice == `SCRST_AXIS_Z);
      o_selftest_direction <= selftest_direction;
      o_three_wire         <= next_three_wire;
      o_data_out_oe_allow  <= !next_three_wire;
      o_fsr                <= fsr;
      o_active             <= active;
      // Retained straps are only latched outside the soft reset pulse
      if (!int_reset) begin
        o_keep_irq_pin_polarity   <= i_irq_pin_polarity;
        o_keep_irq_pin_drive_type <= i_irq_pin_drive_type;
        o_keep_boot_pulse_disable <= i_boot_pulse_disable;
      end
    end
  end
endmodule

// ---- test/scrst_host.sv ----
// Host controller model that issues single-byte register transfers
`timescale 1ns/10ps
module scrst_host (
  input  wire       i_clk,
  output reg        o_wr_en,
  output reg        o_rd_en,
  output reg  [7:0] o_addr,
  output reg  [7:0] o_wr_data,
  output reg        o_txn_end
);
  initial begin
    o_wr_en   = 1'b0;
    o_rd_en   = 1'b0;
    o_addr    = 8'h00;
    o_wr_data = 8'h00;
    o_txn_end = 1'b1;
  end
  // Stop or chip-select release can be delayed to stretch the transaction
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input int hold);
    begin
      @(posedge i_clk);
      o_txn_end <= 1'b0;
      o_wr_en   <= wr;
      o_rd_en   <= ~wr;
      o_addr    <= a;
      o_wr_data <= d;
      @(posedge i_clk);
      o_wr_en   <= 1'b0;
      o_rd_en   <= 1'b0;
      // Released lines show no stale value
      o_addr    <= ~a;
      o_wr_data <= ~d;
      repeat (hold) @(posedge i_clk);
      o_txn_end <= 1'b1;
    end
  endtask
endmodule

// ---- test/scrst_ctrl_props.sv ----
// Port assertions for the sensor control register block
`timescale 1ns/10ps
module scrst_props (
  input  wire       i_clk,
  input  wire       i_srst,
  input  wire       i_wr_en,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_txn_end,
  input  wire       i_host_interface_choice_pin,
  input  wire       i_lines_tied,
  input  wire [7:0] o_rd_data,
  input  wire       o_soft_reset,
  input  wire       o_bus_reset,
  input  wire       o_reset_pending,
  input  wire       o_selftest_on,
  input  wire       o_selftest_x,
  input  wire       o_selftest_z,
  input  wire       o_selftest_direction,
  input  wire       o_three_wire,
  input  wire       o_data_out_oe_allow
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence wr_ctrl;
    i_wr_en && i_addr == 8'h15 && !i_wr_data[7] && !o_reset_pending && !o_soft_reset;
  endsequence
  sequence pulse_body;
    o_soft_reset [*4] ##1 !o_soft_reset;
  endsequence
  a_read_top_zero: assert property (o_rd_data[7] == 1'b0) else $error("trigger bit read as one");
  a_pulse_four_long: assert property ($rose(o_soft_reset) |-> pulse_body)
    else $error("soft reset pulse length wrong");
  a_bus_reset_pair: assert property (o_bus_reset == o_soft_reset) else $error("bus reset differs");
  a_hold_for_stop: assert property ((o_reset_pending && !i_txn_end) [*3] |=> !$rose(o_soft_reset))
    else $error("reset began inside transaction");
  a_start_delay_window: assert property ($rose(i_txn_end) && o_reset_pending |-> ##[10:20] $rose(o_soft_reset))
    else $error("reset start delay out of window");
  a_axis_decode: assert property (wr_ctrl |-> ##2 {o_selftest_x, o_selftest_z, o_selftest_on} ==
    {$past(i_wr_data[6:5], 2) == 2'h1, $past(i_wr_data[6:5], 2) == 2'h2, $past(i_wr_data[6:5], 2) != 2'h0})
    else $error("axis decode wrong");
  a_dir_follow: assert property (wr_ctrl |-> ##2 o_selftest_direction == $past(i_wr_data[4], 2))
    else $error("direction wrong");
  a_wire_mode_sel: assert property (wr_ctrl |-> ##2 o_three_wire ==
    (i_host_interface_choice_pin && ($past(i_wr_data[3], 2) || i_lines_tied))) else $error("wire mode wrong");
  a_out_pin_float: assert property (o_three_wire [*2] |-> !o_data_out_oe_allow)
    else $error("data-out driven in 3-wire");
endmodule
bind scrst_ctrl scrst_props chk (.i_clk, .i_srst, .i_wr_en, .i_addr, .i_wr_data, .i_txn_end,
  .i_host_interface_choice_pin, .i_lines_tied, .o_rd_data, .o_soft_reset, .o_bus_reset,
  .o_reset_pending, .o_selftest_on, .o_selftest_x, .o_selftest_z, .o_selftest_direction,
  .o_three_wire, .o_data_out_oe_allow);

// ---- test/tb_scrst_ctrl.sv ----
// Self-checking bench for the sensor control register block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_scrst_ctrl;
  logic        i_clk = 1'b0, i_srst = 1'b1, spi = 1'b1, tied = 1'b0, hib = 1'b0;
  logic [2:0]  keep = 3'h5;
  logic [7:0]  d;
  logic [31:0] seed = 32'h0000002D;
  wire         we, re, te, sr, br, pend, on, sx, sz, dir, w3, oe, act;
  wire  [7:0]  a, wd, rd;
  wire  [1:0]  fsr;
  wire  [2:0]  kept;
  int          err_count = 0, n_compared = 0, cnt;
  always #50 i_clk = ~i_clk;
  // Delay shortened to 10 cycles to keep the run brief
  scrst_ctrl #(.DELAY_US(1)) uut (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(we), .i_rd_en(re),
    .i_addr(a), .i_wr_data(wd), .i_txn_end(te), .i_host_interface_choice_pin(spi),
    .i_lines_tied(tied), .i_hibernate_exit(hib), .i_irq_pin_polarity(keep[0]),
    .i_irq_pin_drive_type(keep[1]), .i_boot_pulse_disable(keep[2]), .o_rd_data(rd),
    .o_soft_reset(sr), .o_bus_reset(br), .o_reset_pending(pend), .o_selftest_on(on),
    .o_selftest_x(sx), .o_selftest_z(sz), .o_selftest_direction(dir), .o_three_wire(w3),
    .o_data_out_oe_allow(oe), .o_fsr(fsr), .o_active(act), .o_keep_irq_pin_polarity(kept[0]),
    .o_keep_irq_pin_drive_type(kept[1]), .o_keep_boot_pulse_disable(kept[2]));
  scrst_host host (.i_clk(i_clk), .o_wr_en(we), .o_rd_en(re), .o_addr(a), .o_wr_data(wd),
    .o_txn_end(te));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk_fields(input logic [7:0] v);
    begin
      host.xfer(1'b0, 8'h15, 8'h00, 0);
      #1;
      `CHK(rd, {1'b0, v[6:0]})
      `CHK({sx, sz, on}, {v[6:5] == 2'h1, v[6:5] == 2'h2, v[6:5] != 2'h0})
      `CHK({fsr, act}, v[2:0])
      `CHK(dir, v[4])
      `CHK(w3, spi & (v[3] | tied))
      `CHK(oe, ~(spi & (v[3] | tied)))
    end
  endtask
  task automatic stop_test;
    begin
      $display("errors %0d compares %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk_fields(8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      @(posedge i_clk);
      {tied, spi} <= {i[3], ~i[2]};
      keep <= seed[7:5];
      repeat (4) @(posedge i_clk);
      d = {1'b0, i[1:0], seed[4:0]};
      // One write and one read per pass, four passes per self-test setting, keeps bus traffic low
      host.xfer(1'b1, 8'h15, d, 0);
      chk_fields(d);
    end
    // Unmapped address neither writes nor reads back
    host.xfer(1'b1, 8'h16, 8'h7F, 0);
    chk_fields(d);
    host.xfer(1'b0, 8'h16, 8'h00, 0);
    #1;
    `CHK(rd, 8'h00)
    @(posedge i_clk);
    {tied, spi} <= 2'h1;
    repeat (4) @(posedge i_clk);
    host.xfer(1'b1, 8'h15, 8'h08, 0);
    chk_fields(8'h08);
    @(posedge i_clk);
    hib <= 1'b1;
    repeat (6) @(posedge i_clk);
    hib <= 1'b0;
    #1;
    `CHK(w3, 1'b0)
    for (int m = 0; m < 2; m++) begin
      host.xfer(1'b1, 8'h15, {7'h34, m[0]}, 0);
      // Nonzero retained bits so that a cleared copy would show
      keep <= 3'h5 ^ {3{m[0]}};
      host.xfer(1'b1, 8'h15, 8'h80, 20);
      #1;
      `CHK(sr, 1'b0)
      `CHK(pend, 1'b1)
      cnt = 0;
      while (sr !== 1'b1 && cnt < 40) begin
        @(posedge i_clk);
        #1;
        cnt++;
      end
      `CHK(cnt inside {[10:20]}, 1'b1)
      `CHK(br, 1'b1)
      `CHK(kept, keep)
      if (cnt == 40) stop_test();
      // Host stays quiet until the pulse has ended
      repeat (6) @(posedge i_clk);
      `CHK(kept, keep)
      chk_fields(8'h00);
    end
    stop_test();
  end
endmodule
